// File: fpec_dev.sv
// flash program/erase sequencer with its control registers
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "fpec_consts.svh"
// Contract
// - only 0x55 or 0xaa start an erase
// - mass erase arm resets low, one-shot
// - page field bits 7:1 names page
// - pending flag; writes during it dropped
// - deferred write queued until engine busy falls
// - without deferral writes run immediately
// - store goes to flash when enabled
// - program enable clears after each byte
// - program enable writes ignored with interrupts on
// - read allowed equals not lock
// - write allowed status bit
// - key must be 2 to modify
// - lock blocks page0, code area, reads; code bars page erase there but not stores, and for reads only clears rde
module fpec_dev
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    fpec_if.dev bus,
    input wire logic [6:0] code_page_i,
    output logic flash_we_o,
    output logic flash_page_erase_o,
    output logic flash_mass_erase_o,
    output logic [15:0] flash_addr_o,
    output logic [7:0] flash_data_o,
    output logic [6:0] erase_page_o,
    output logic flash_busy_o
);
    import fpec_pkg::*;
    fpec_state_t state_q, state_d;
    logic [7:0] rdata_q;
    logic xram_q;
    logic pwe_q, meen_q, pstwr_q, lock_q;
    logic [6:0] page_q;
    logic [3:0] key_q;
    logic [15:0] qaddr_q;
    logic [7:0] qdata_q;
    logic busy_dly_q;
    logic [3:0] cnt_q;
    logic we_q, pe_q, me_q;
    wire sel_erase = bus.wr && bus.addr == `FPEC_ADDR_ERASE;
    wire sel_ctl = bus.wr && bus.addr == `FPEC_ADDR_CTL;
    wire sel_page = bus.wr && bus.addr == `FPEC_ADDR_PAGE;
    wire sel_sec = bus.wr && bus.addr == `FPEC_ADDR_SEC;
    wire key_ok = key_q == `FPEC_KEY_OK;
    wire pend = state_q != FPEC_ST_IDLE;
    // locked pages: page 0 and the engine code area
    wire page_locked = lock_q && (page_q == 7'h00 || page_q >= code_page_i);
    wire rde = ~lock_q;
    wire wre = key_ok & ~lock_q;
    wire prog_req = bus.movx_wr & pwe_q;
    wire page_cmd = sel_erase && bus.wdata == `FPEC_CMD_PAGE && page_q <= `FPEC_PAGE_MAX;
    wire mass_cmd = sel_erase && bus.wdata == `FPEC_CMD_MASS && meen_q && bus.dbg_en;
    wire do_prog = prog_req & key_ok & ~pend;
    wire do_page = page_cmd & key_ok & ~pend & ~page_locked;
    wire do_mass = mass_cmd & key_ok & ~pend & ~lock_q;
    wire defer = pstwr_q & bus.ce_en;
    wire busy_fall = busy_dly_q & ~bus.ce_busy;
    wire [7:0] ctl_rd = {1'b0, lock_q, 2'b00, pend, pstwr_q, 1'b0, pwe_q};
    wire [7:0] sec_rd = {key_q, 1'b0, rde, wre, 1'b0};
    wire [7:0] rd_mux = bus.addr == `FPEC_ADDR_CTL ? ctl_rd :
        bus.addr == `FPEC_ADDR_SEC ? sec_rd :
        bus.addr == `FPEC_ADDR_STAT ? {7'h00, pend} : 8'h00;
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            FPEC_ST_IDLE:
            begin
                if (do_prog && defer)
                    state_d = FPEC_ST_WAIT;
                else if (do_prog || do_page || do_mass)
                    state_d = FPEC_ST_BUSY;
            end
            FPEC_ST_WAIT:
            begin
                if (busy_fall)
                    state_d = FPEC_ST_BUSY;
            end
            FPEC_ST_BUSY:
            begin
                if (cnt_q == 4'h0)
                    state_d = FPEC_ST_IDLE;
            end
            default:
                state_d = FPEC_ST_IDLE;
        endcase
    end
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_q <= FPEC_ST_IDLE;
            rdata_q <= 8'h00;
            xram_q <= 1'b0;
            pwe_q <= 1'b0;
            meen_q <= 1'b0;
            pstwr_q <= 1'b0;
            lock_q <= 1'b0;
            page_q <= 7'h00;
            key_q <= 4'h0;
            qaddr_q <= 16'h0000;
            qdata_q <= 8'h00;
            busy_dly_q <= 1'b0;
            cnt_q <= 4'h0;
            we_q <= 1'b0;
            pe_q <= 1'b0;
            me_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            rdata_q <= bus.rd ? rd_mux : 8'h00;
            // plain store goes to external ram
            xram_q <= bus.movx_wr & ~pwe_q;
            busy_dly_q <= bus.ce_busy;
            // enable clears after a byte, locked out under interrupts
            if (do_prog)
                pwe_q <= 1'b0;
            else if (sel_ctl && !bus.int_en)
                pwe_q <= bus.wdata[`FPEC_BIT_PWE];
            // arm consumed by any erase command
            if (sel_erase)
                meen_q <= 1'b0;
            else if (sel_ctl)
                meen_q <= bus.wdata[`FPEC_BIT_MEEN];
            if (sel_ctl)
                pstwr_q <= bus.wdata[`FPEC_BIT_PSTWR];
            if (sel_ctl)
                lock_q <= lock_q | bus.wdata[`FPEC_BIT_LOCK];
            // page field sits in bits 7:1
            if (sel_page)
                page_q <= bus.wdata[7:1];
            if (sel_sec)
                key_q <= bus.wdata[7:4];
            if (do_prog)
            begin
                qaddr_q <= bus.dptr;
                qdata_q <= bus.acc;
            end
            we_q <= 1'b0;
            pe_q <= 1'b0;
            me_q <= 1'b0;
            // immediate launch, launch on busy fall
            if ((state_q == FPEC_ST_IDLE && state_d == FPEC_ST_BUSY) ||
                (state_q == FPEC_ST_WAIT && busy_fall))
            begin
                cnt_q <= 4'(`FPEC_OP_CYC - 1);
                we_q <= do_prog | (state_q == FPEC_ST_WAIT);
                // a store in the same cycle wins, so only one strobe fires
                pe_q <= do_page & ~do_prog;
                me_q <= do_mass & ~do_prog;
            end
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
        end
    end
    assign bus.rdata = rdata_q;
    assign bus.xram_wr = xram_q;
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flash_we_o <= 1'b0;
            flash_page_erase_o <= 1'b0;
            flash_mass_erase_o <= 1'b0;
            flash_addr_o <= 16'h0000;
            flash_data_o <= 8'h00;
            erase_page_o <= 7'h00;
            flash_busy_o <= 1'b0;
        end
        else
        begin
            flash_we_o <= we_q;
            flash_page_erase_o <= pe_q;
            flash_mass_erase_o <= me_q;
            flash_addr_o <= qaddr_q;
            flash_data_o <= qdata_q;
            erase_page_o <= page_q;
            flash_busy_o <= pend;
        end
    end
endmodule
`default_nettype wire

// File: fpec_consts.svh
// constants for the flash program/erase control block
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH
`define FPEC_ADDR_ERASE 16'h0094
`define FPEC_ADDR_CTL 16'h00b2
`define FPEC_ADDR_PAGE 16'h00b7
`define FPEC_ADDR_SEC 16'h2702
`define FPEC_ADDR_STAT 16'h0f00
`define FPEC_CMD_PAGE 8'h55
`define FPEC_CMD_MASS 8'haa
`define FPEC_KEY_OK 4'h2
`define FPEC_BIT_PWE 0
`define FPEC_BIT_MEEN 1
`define FPEC_BIT_PSTWR 2
`define FPEC_BIT_PEND 3
`define FPEC_BIT_LOCK 6
`define FPEC_BIT_RDE 2
`define FPEC_BIT_WRE 1
`define FPEC_PAGE_MAX 7'h3f
`define FPEC_OP_NS 40
`define FPEC_OP_CYC ((`FPEC_OP_NS + 7) / 8)
`endif

// File: fpec_pkg.sv
// types for the flash program/erase control block
`default_nettype none
package fpec_pkg;
    typedef enum logic [1:0] {
        FPEC_OP_NONE = 2'h0,
        FPEC_OP_PROG = 2'h1,
        FPEC_OP_PAGE = 2'h2,
        FPEC_OP_MASS = 2'h3
    } fpec_op_t;
    typedef enum logic [2:0] {
        FPEC_ST_IDLE = 3'b001,
        FPEC_ST_WAIT = 3'b010,
        FPEC_ST_BUSY = 3'b100
    } fpec_state_t;
endpackage
`default_nettype wire

// File: fpec_if.sv
// link between the flash controller and its processor-side partner
`timescale 1ns/1ns
`default_nettype none
interface fpec_if;
    import fpec_pkg::*;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic movx_wr;
    logic [15:0] dptr;
    logic [7:0] acc;
    logic int_en;
    logic ce_en;
    logic ce_busy;
    logic dbg_en;
    logic xram_wr;
    modport dev (input addr, wdata, wr, rd, movx_wr, dptr, acc, int_en, ce_en, ce_busy,
        dbg_en, output rdata, xram_wr);
    modport cpu (output addr, wdata, wr, rd, movx_wr, dptr, acc, int_en, ce_en, ce_busy,
        dbg_en, input rdata, xram_wr);
endinterface
`default_nettype wire

// File: fpec_cpu.sv
// processor-side end: turns user commands into register and store cycles
`timescale 1ns/1ns
`default_nettype none
module fpec_cpu
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    fpec_if.cpu bus,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic store_i,
    input wire logic [15:0] dptr_i,
    input wire logic [7:0] acc_i,
    input wire logic int_en_i,
    input wire logic ce_en_i,
    input wire logic ce_busy_i,
    input wire logic dbg_en_i,
    output logic [7:0] rdata_o,
    output logic xram_wr_o
);
    import fpec_pkg::*;
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            bus.addr <= 16'h0000;
            bus.wdata <= 8'h00;
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.movx_wr <= 1'b0;
            bus.dptr <= 16'h0000;
            bus.acc <= 8'h00;
            bus.int_en <= 1'b0;
            bus.ce_en <= 1'b0;
            bus.ce_busy <= 1'b0;
            bus.dbg_en <= 1'b0;
            rdata_o <= 8'h00;
            xram_wr_o <= 1'b0;
        end
        else
        begin
            // software reloads arm and page per operation; the key is written once and held
            bus.addr <= addr_i;
            bus.wdata <= wdata_i;
            bus.wr <= wr_i;
            bus.rd <= rd_i & ~wr_i;
            bus.movx_wr <= store_i;
            bus.dptr <= dptr_i;
            bus.acc <= acc_i;
            // interrupt state presented to the device
            bus.int_en <= int_en_i;
            bus.ce_en <= ce_en_i;
            bus.ce_busy <= ce_busy_i;
            bus.dbg_en <= dbg_en_i;
            rdata_o <= bus.rdata;
            xram_wr_o <= bus.xram_wr;
        end
    end
endmodule
`default_nettype wire

// File: fpec_sva.sv
// assertions on the flash control link and the flash strobes
`timescale 1ns/1ns
`default_nettype none
module fpec_sva
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic dbg_en,
    input wire logic flash_we_o,
    input wire logic flash_page_erase_o,
    input wire logic flash_mass_erase_o,
    input wire logic flash_busy_o
);
    logic [3:0] key_q;
    logic lock_q;
    wire sec_rd = rd && addr == 16'h2702;
    wire sec_wr = wr && addr == 16'h2702;
    wire ers_wr = wr && addr == 16'h0094;
    wire any_op = flash_we_o || flash_page_erase_o || flash_mass_erase_o;
    // shadow of key and set-only lock
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            key_q <= 4'h0;
            lock_q <= 1'b0;
        end
        else
        begin
            if (sec_wr)
                key_q <= wdata[7:4];
            if (wr && addr == 16'h00b2 && wdata[6])
                lock_q <= 1'b1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    a_read_allowed: assert property (sec_rd |=> rdata[2] == !lock_q)
        else $error("read allowed bit wrong");
    a_write_allowed: assert property (sec_rd |=> rdata[1] == ($past(key_q) == 4'h2 && !lock_q))
        else $error("write allowed bit wrong");
    a_key_readback: assert property (sec_rd |=> rdata[7:4] == $past(key_q))
        else $error("key field readback wrong");
    a_key_blocks_op: assert property ((key_q != 4'h2) [*4] |-> !any_op)
        else $error("flash operation without key");
    a_single_op: assert property (any_op |-> $onehot({flash_we_o, flash_page_erase_o,
        flash_mass_erase_o}) ##1 !any_op)
        else $error("flash strobes overlap or stretch");
    a_bad_pattern: assert property (ers_wr && wdata != 8'h55 && wdata != 8'haa
        |=> !(flash_page_erase_o || flash_mass_erase_o) [*3])
        else $error("erase from a wrong pattern");
    a_page_fires: assert property (ers_wr && wdata == 8'h55 && key_q == 4'h2 && !lock_q
        && !flash_busy_o |-> ##[1:3] flash_page_erase_o)
        else $error("page erase not started");
    a_mass_guard: assert property (flash_mass_erase_o |-> $past(dbg_en, 2) && !$past(lock_q, 2))
        else $error("mass erase not permitted");
    a_we_in_busy: assert property (flash_we_o |-> flash_busy_o)
        else $error("flash write without pending");
endmodule
`default_nettype wire

// File: tb_flash_program_erase_control.sv
// self-checking bench for the flash control pair
`timescale 1ns/1ns
`default_nettype none
module tb_flash_program_erase_control;
    logic clk, rst_n, wr, rd, st, ie, cee, ceb, dbg, xw, we, pe, me, busy;
    logic [15:0] ad, dp, fa;
    logic [7:0] wd, ac, rdo, fd, v;
    logic [6:0] pg;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    wire [3:0] pulses = {xw, me, pe, we};
    fpec_if lnk();
    fpec_cpu fpec_cpu_inst (.clock_i(clk), .arst_n_i(rst_n), .bus(lnk.cpu), .addr_i(ad),
        .wdata_i(wd), .wr_i(wr), .rd_i(rd), .store_i(st), .dptr_i(dp), .acc_i(ac),
        .int_en_i(ie), .ce_en_i(cee), .ce_busy_i(ceb), .dbg_en_i(dbg), .rdata_o(rdo),
        .xram_wr_o(xw));
    fpec_dev fpec_dev_inst (.clock_i(clk), .arst_n_i(rst_n), .bus(lnk.dev), .code_page_i(7'h10),
        .flash_we_o(we), .flash_page_erase_o(pe), .flash_mass_erase_o(me), .flash_addr_o(fa),
        .flash_data_o(fd), .erase_page_o(pg), .flash_busy_o(busy));
    fpec_sva fpec_sva_inst (.clock_i(clk), .arst_n_i(rst_n), .addr(lnk.addr), .wdata(lnk.wdata),
        .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata), .dbg_en(lnk.dbg_en), .flash_we_o(we),
        .flash_page_erase_o(pe), .flash_mass_erase_o(me), .flash_busy_o(busy));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic lv(input logic [3:0] l);
        @(posedge clk);
        {ie, cee, ceb, dbg} <= l;
    endtask
    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        ad <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [15:0] a, output logic [7:0] r);
        @(posedge clk);
        ad <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        repeat (2) @(posedge clk);
        #1 r = rdo;
    endtask
    task automatic store(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        dp <= a;
        ac <= d;
        st <= 1'b1;
        @(posedge clk);
        st <= 1'b0;
    endtask
    // watch one strobe for a bounded span
    task automatic waitp(input int s, input logic e);
        logic h;
        h = 1'b0;
        repeat (12)
        begin
            @(posedge clk);
            #1 h = h | pulses[s];
        end
        chk(h, e);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1500)
        begin
            err_total++;
            final_report();
        end
    end
    initial
    begin
        {rst_n, wr, rd, st, ie, cee, ceb, dbg} = '0;
        {ad, dp, wd, ac} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rreg(16'h0094, v);
        chk(v, 8'h00);
        rreg(16'h2702, v);
        chk(v & 8'hf6, 8'h04);
        wreg(16'h2702, 8'h20);
        rreg(16'h2702, v);
        chk(v & 8'hf6, 8'h26);
        lv(4'b1000);
        wreg(16'h00b2, 8'h01);
        rreg(16'h00b2, v);
        chk(v[0], 1'b0);
        lv(4'b0000);
        wreg(16'h00b2, 8'h01);
        store(16'h1234, 8'h5a);
        waitp(0, 1'b1);
        chk(fa, 16'h1234);
        chk(fd, 8'h5a);
        rreg(16'h00b2, v);
        chk(v[0], 1'b0);
        store(16'h0040, 8'h11);
        waitp(3, 1'b1);
        lv(4'b0110);
        wreg(16'h00b2, 8'h05);
        store(16'h2000, 8'h33);
        waitp(0, 1'b0);
        chk(busy, 1'b1);
        rreg(16'h00b2, v);
        chk(v[3], 1'b1);
        rreg(16'h0f00, v);
        chk(v, 8'h01);
        // re-arm so the second store really targets flash while pending
        wreg(16'h00b2, 8'h05);
        store(16'h2001, 8'h44);
        lv(4'b0100);
        waitp(0, 1'b1);
        chk(fd, 8'h33);
        chk(fa, 16'h2000);
        wreg(16'h00b7, 8'h7e);
        wreg(16'h0094, 8'h55);
        waitp(1, 1'b1);
        chk(pg, 7'h3f);
        wreg(16'h0094, 8'h33);
        waitp(1, 1'b0);
        lv(4'b0001);
        wreg(16'h0094, 8'haa);
        waitp(2, 1'b0);
        wreg(16'h00b2, 8'h02);
        wreg(16'h0094, 8'haa);
        waitp(2, 1'b1);
        wreg(16'h0094, 8'haa);
        waitp(2, 1'b0);
        wreg(16'h00b2, 8'h40);
        rreg(16'h2702, v);
        chk(v & 8'hf6, 8'h20);
        wreg(16'h00b7, 8'h00);
        wreg(16'h0094, 8'h55);
        waitp(1, 1'b0);
        wreg(16'h00b7, 8'h10);
        wreg(16'h0094, 8'h55);
        waitp(1, 1'b1);
        chk(pg, 7'h08);
        wreg(16'h00b7, 8'h40);
        wreg(16'h0094, 8'h55);
        waitp(1, 1'b0);
        wreg(16'h00b2, 8'h42);
        wreg(16'h0094, 8'haa);
        waitp(2, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
